/* hw/dsadc_pkg.sv */
// Constants, register map and types for the delta-sigma conversion control
package dsadc_pkg;
    // ****************************************
    // Clock and timing
    // ****************************************
    localparam int unsigned CLK_HZ = 40000000;
    localparam int unsigned MOD_DIV = 3;
    localparam int unsigned NOM_RATE_SPS = 192000;
    localparam int unsigned NOM_BITS = 12;
    // Ratio that brings the nominal rate from the modulator rate
    localparam logic [7:0] RATIO_DEF = 8'(CLK_HZ / (MOD_DIV * NOM_RATE_SPS));
    // Sinc3 gain of about 19 bits trimmed down to the nominal width
    localparam logic [4:0] SHIFT_DEF = 5'h07;
    localparam logic [1:0] DIV_LAST = 2'(MOD_DIV - 1);
    localparam logic [1:0] SETTLE_LAST = 2'h3;

    // ****************************************
    // Widths
    // ****************************************
    localparam int unsigned ADDR_W = 5;
    localparam int unsigned DATA_W = 32;
    localparam int unsigned DEC_W = 26;
    localparam int unsigned SUM_W = 33;

    // ****************************************
    // Register offsets
    // ****************************************
    localparam logic [4:0] CTRL_OFS = 5'h00;
    localparam logic [4:0] CFG_OFS = 5'h04;
    localparam logic [4:0] CHAN_OFS = 5'h08;
    localparam logic [4:0] STAT_OFS = 5'h0c;
    localparam logic [4:0] RESULT_OFS = 5'h10;

    // ****************************************
    // Field positions
    // ****************************************
    localparam int unsigned CTRL_MODE_LSB = 0;
    localparam int unsigned CTRL_BUF_BIT = 2;
    localparam int unsigned CTRL_START_BIT = 3;
    localparam int unsigned CTRL_STOP_BIT = 4;
    localparam int unsigned CFG_RATIO_LSB = 0;
    localparam int unsigned CFG_SHIFT_LSB = 8;
    localparam int unsigned CFG_AVG_LSB = 16;
    localparam int unsigned STAT_DONE_BIT = 0;
    localparam int unsigned STAT_BUSY_BIT = 1;
    localparam int unsigned STAT_VALID_BIT = 2;

    // ****************************************
    // Reset values
    // ****************************************
    localparam logic [2:0] AVG_DEF = 3'h0;
    localparam logic [3:0] CHAN_DEF = 4'h0;
    localparam logic BUF_DEF = 1'b0;

    typedef enum logic [1:0] {
        MODE_SINGLE,
        MODE_FAST_FILT,
        MODE_CONT,
        MODE_FAST_AVG
    } dsadc_mode_e;

    typedef enum logic [1:0] {
        ST_IDLE,
        ST_RUN,
        ST_HOLD
    } dsadc_state_e;
endpackage

/* hw/dsadc_sinc.sv */
// Third-order sinc decimator turning the modulator bitstream into words
`timescale 1ns/1ps
module dsadc_sinc (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic clr,
    input wire logic sample_en,
    input wire logic bit_in,
    input wire logic [7:0] ratio,
    output logic [dsadc_pkg::DEC_W-1:0] dout,
    output logic dvalid
);
    localparam int unsigned W = dsadc_pkg::DEC_W;

    logic [W-1:0] integ_reg [3];
    logic [W-1:0] delay_reg [3];
    logic [W-1:0] comb [3];
    logic [7:0] cnt_reg;
    logic decim;

    assign decim = sample_en && (cnt_reg == ratio - 8'h01);

    // ****************************************
    // Integrators and combs
    // ****************************************
    // Wrapping arithmetic is harmless: the combs undo it exactly
    for (genvar k = 0; k < 3; k++) begin : g_stage
        logic [W-1:0] integ_in;
        logic [W-1:0] comb_in;
        if (k == 0) begin : g_first
            assign integ_in = {{(W-1){1'b0}}, bit_in};
            assign comb_in = integ_reg[2];
        end else begin : g_next
            assign integ_in = integ_reg[k-1];
            assign comb_in = comb[k-1];
        end
        assign comb[k] = comb_in - delay_reg[k];
        always_ff @(posedge clk) begin
            if (!rst_n || clr) begin
                integ_reg[k] <= '0;
                delay_reg[k] <= '0;
            end else begin
                if (sample_en) begin
                    integ_reg[k] <= integ_reg[k] + integ_in;
                end
                if (decim) begin
                    delay_reg[k] <= comb_in;
                end
            end
        end
    end

    // ****************************************
    // Decimation counter and output
    // ****************************************
    always_ff @(posedge clk) begin
        if (!rst_n || clr) begin
            cnt_reg <= 8'h00;
            dout <= '0;
            dvalid <= 1'b0;
        end else begin
            dvalid <= decim;
            if (decim) begin
                cnt_reg <= 8'h00;
                dout <= comb[2];
            end else if (sample_en) begin
                cnt_reg <= cnt_reg + 8'h01;
            end
        end
    end
endmodule

/* hw/dsadc_ctrl.sv */
// Conversion control of the delta-sigma converter: modes, start, completion
//
// Behaviour
// - Decimator turns modulator bitstream into words; ratio and resolution set by config.
// - A result needs four filter outputs; channel change restarts that count.
// - Four modes: single sample, fast filter, continuous, fast average.
// - Every mode starts on a control-bit write or a start input edge.
// - Completion sets the done flag and end-of-conversion, held until read.
// - Single mode waits in standby, then does exactly one conversion.
// - Single mode returns to standby once its result is read.
// - Continuous mode resets once, then converts until stopped.
// - Fast filter resets the filter after each result and starts again.
// - Fast average resets the modulator only at start; sinc1 sums extra results.
// - Start input is optional; continuous mode runs with it tied low.
// - End-of-conversion is an output usable as interrupt or DMA request.
// - A config bit routes the input via the buffer or directly.
// - Reset configuration gives 12-bit results near 192 ksps.
//
// Local design decisions: the placing of the registers and the address-and-strobe port.
`timescale 1ns/1ps
module dsadc_ctrl (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic [dsadc_pkg::ADDR_W-1:0] addr,
    input wire logic [dsadc_pkg::DATA_W-1:0] wdata,
    input wire logic wr,
    input wire logic rd,
    output logic [dsadc_pkg::DATA_W-1:0] rdata,
    input wire logic mod_bit,
    input wire logic soc,
    output logic mod_en,
    output logic mod_rst,
    output logic buf_en,
    output logic [3:0] in_sel,
    output logic eoc
);
    // ****************************************
    // Declarations
    // ****************************************
    logic [1:0] sync1_reg, sync2_reg, sync3_reg, stab_reg;
    logic soc_prev_reg;
    logic [1:0] div_reg;
    dsadc_pkg::dsadc_mode_e mode_reg;
    dsadc_pkg::dsadc_state_e state_reg;
    logic [7:0] ratio_reg;
    logic [4:0] shift_reg;
    logic [2:0] avg_reg;
    logic [1:0] settle_reg;
    logic [6:0] avg_cnt_reg;
    logic [dsadc_pkg::SUM_W-1:0] sum_reg;
    logic [dsadc_pkg::DATA_W-1:0] result_reg;
    logic done_reg;
    logic clr_reg;
    logic [dsadc_pkg::DEC_W-1:0] dec_out;
    logic dec_valid;
    logic ctrl_wr, chan_wr, res_rd;
    logic start_evt, stop_evt, soc_edge;
    logic settled_out, avg_last, capture;
    logic [dsadc_pkg::SUM_W-1:0] sum_next;
    logic [dsadc_pkg::SUM_W-1:0] shifted;

    // ****************************************
    // Pin synchronisers
    // ****************************************
    // Bit 0 carries the modulator stream, bit 1 the start input
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            sync1_reg <= 2'h0;
            sync2_reg <= 2'h0;
            sync3_reg <= 2'h0;
            stab_reg <= 2'h0;
            soc_prev_reg <= 1'b0;
        end else begin
            sync1_reg <= {soc, mod_bit};
            sync2_reg <= sync1_reg;
            sync3_reg <= sync2_reg;
            stab_reg <= (~(sync2_reg ^ sync3_reg) & sync3_reg) | ((sync2_reg ^ sync3_reg) & stab_reg);
            soc_prev_reg <= stab_reg[1];
        end
    end

    // tied low safe
    // Only edges count, so a start input held low never fires
    assign soc_edge = stab_reg[1] && !soc_prev_reg;

    // ****************************************
    // Modulator rate divider
    // ****************************************
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            div_reg <= 2'h0;
        end else if (div_reg == dsadc_pkg::DIV_LAST) begin
            div_reg <= 2'h0;
        end else begin
            div_reg <= div_reg + 2'h1;
        end
    end
    assign mod_en = (div_reg == dsadc_pkg::DIV_LAST);

    // ****************************************
    // Decimator
    // ****************************************
    // bitstream decimation
    dsadc_sinc u_sinc (
        .clk(clk),
        .rst_n(rst_n),
        .clr(clr_reg),
        .sample_en(mod_en),
        .bit_in(stab_reg[0]),
        .ratio(ratio_reg),
        .dout(dec_out),
        .dvalid(dec_valid)
    );

    // ****************************************
    // Register writes
    // ****************************************
    assign ctrl_wr = wr && (addr == dsadc_pkg::CTRL_OFS);
    assign chan_wr = wr && (addr == dsadc_pkg::CHAN_OFS);
    assign res_rd = rd && (addr == dsadc_pkg::RESULT_OFS);
    assign start_evt = (ctrl_wr && wdata[dsadc_pkg::CTRL_START_BIT]) || soc_edge;
    assign stop_evt = ctrl_wr && wdata[dsadc_pkg::CTRL_STOP_BIT];

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            mode_reg <= dsadc_pkg::MODE_SINGLE;
            buf_en <= dsadc_pkg::BUF_DEF;
            ratio_reg <= dsadc_pkg::RATIO_DEF;
            shift_reg <= dsadc_pkg::SHIFT_DEF;
            avg_reg <= dsadc_pkg::AVG_DEF;
            in_sel <= dsadc_pkg::CHAN_DEF;
        end else begin
            if (ctrl_wr) begin
                mode_reg <= dsadc_pkg::dsadc_mode_e'(wdata[dsadc_pkg::CTRL_MODE_LSB +: 2]);
                buf_en <= wdata[dsadc_pkg::CTRL_BUF_BIT];
            end
            if (wr && addr == dsadc_pkg::CFG_OFS) begin
                ratio_reg <= wdata[dsadc_pkg::CFG_RATIO_LSB +: 8];
                shift_reg <= wdata[dsadc_pkg::CFG_SHIFT_LSB +: 5];
                avg_reg <= wdata[dsadc_pkg::CFG_AVG_LSB +: 3];
            end
            if (chan_wr) begin
                in_sel <= wdata[3:0];
            end
        end
    end

    // ****************************************
    // Result qualification
    // ****************************************
    // fourth output valid
    assign settled_out = dec_valid && (state_reg == dsadc_pkg::ST_RUN) && (settle_reg == dsadc_pkg::SETTLE_LAST);
    assign avg_last = (avg_cnt_reg == 7'((8'h01 << avg_reg) - 8'h01));
    assign capture = settled_out && !start_evt && !chan_wr && (mode_reg != dsadc_pkg::MODE_FAST_AVG || avg_last);
    assign sum_next = sum_reg + {{(dsadc_pkg::SUM_W-dsadc_pkg::DEC_W){1'b0}}, dec_out};
    assign shifted = sum_next >> shift_reg;

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            settle_reg <= 2'h0;
        end else if (start_evt || chan_wr || clr_reg) begin
            settle_reg <= 2'h0;
        end else if (dec_valid && state_reg == dsadc_pkg::ST_RUN && settle_reg != dsadc_pkg::SETTLE_LAST) begin
            settle_reg <= settle_reg + 2'h1;
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            avg_cnt_reg <= 7'h00;
            sum_reg <= '0;
        end else if (start_evt || chan_wr || capture) begin
            avg_cnt_reg <= 7'h00;
            sum_reg <= '0;
        end else if (settled_out && mode_reg == dsadc_pkg::MODE_FAST_AVG) begin
            avg_cnt_reg <= avg_cnt_reg + 7'h01;
            sum_reg <= sum_next;
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            result_reg <= '0;
        end else if (capture) begin
            result_reg <= shifted[dsadc_pkg::DATA_W-1:0];
        end
    end

    // ****************************************
    // Sequencer
    // ****************************************
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            state_reg <= dsadc_pkg::ST_IDLE;
        end else if (stop_evt) begin
            state_reg <= dsadc_pkg::ST_IDLE;
        end else if (start_evt) begin
            state_reg <= dsadc_pkg::ST_RUN;
        end else begin
            unique case (state_reg)
                dsadc_pkg::ST_IDLE: begin
                    state_reg <= dsadc_pkg::ST_IDLE;
                end
                dsadc_pkg::ST_RUN: begin
                    if (capture && mode_reg == dsadc_pkg::MODE_SINGLE) begin
                        state_reg <= dsadc_pkg::ST_HOLD;
                    end
                end
                dsadc_pkg::ST_HOLD: begin
                    if (res_rd) begin
                        state_reg <= dsadc_pkg::ST_IDLE;
                    end
                end
                default: begin
                    state_reg <= dsadc_pkg::ST_IDLE;
                end
            endcase
        end
    end

    // Filter and modulator reset pulse
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            clr_reg <= 1'b0;
        end else begin
            clr_reg <= start_evt || (capture && mode_reg == dsadc_pkg::MODE_FAST_FILT);
        end
    end
    assign mod_rst = clr_reg;

    // ****************************************
    // Completion flag
    // ****************************************
    // set wins over read
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            done_reg <= 1'b0;
        end else if (capture) begin
            done_reg <= 1'b1;
        end else if (res_rd) begin
            done_reg <= 1'b0;
        end
    end

    assign eoc = done_reg && !res_rd;

    // ****************************************
    // Register reads
    // ****************************************
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            rdata <= '0;
        end else if (rd) begin
            unique case (addr)
                dsadc_pkg::CTRL_OFS: rdata <= {27'h0, 2'h0, buf_en, mode_reg};
                dsadc_pkg::CFG_OFS: rdata <= {13'h0, avg_reg, 3'h0, shift_reg, ratio_reg};
                dsadc_pkg::CHAN_OFS: rdata <= {28'h0, in_sel};
                dsadc_pkg::STAT_OFS: rdata <= {29'h0, settle_reg == dsadc_pkg::SETTLE_LAST,
                    state_reg != dsadc_pkg::ST_IDLE, done_reg};
                dsadc_pkg::RESULT_OFS: rdata <= result_reg;
                default: rdata <= '0;
            endcase
        end else begin
            rdata <= '0;
        end
    end

    // ****************************************
    // Checks
    // ****************************************
    chk_eoc_read_clear: assert property (
        @(posedge clk) disable iff (!rst_n) res_rd && !capture |-> !eoc ##1 !done_reg)
        else $error("eoc high while result is read");

    chk_done_sets: assert property (
        @(posedge clk) disable iff (!rst_n) capture |=> done_reg && eoc || res_rd)
        else $error("done not set after capture");

    chk_done_holds: assert property (
        @(posedge clk) disable iff (!rst_n) done_reg && !res_rd |=> done_reg)
        else $error("done dropped without a read");

    chk_single_standby: assert property (
        @(posedge clk) disable iff (!rst_n)
        state_reg == dsadc_pkg::ST_HOLD && res_rd && !start_evt && !stop_evt |=> state_reg == dsadc_pkg::ST_IDLE)
        else $error("single mode did not return to standby");

    chk_start_runs: assert property (
        @(posedge clk) disable iff (!rst_n)
        start_evt && !stop_evt |=> state_reg == dsadc_pkg::ST_RUN && mod_rst ##1 (!clr_reg || $past(start_evt)))
        else $error("start did not launch a conversion");

    chk_settle_four: assert property (
        @(posedge clk) disable iff (!rst_n) chan_wr |=> !capture [*3])
        else $error("result taken before four outputs");

    chk_fast_reclear: assert property (
        @(posedge clk) disable iff (!rst_n) capture && mode_reg == dsadc_pkg::MODE_FAST_FILT |=> mod_rst)
        else $error("fast filter did not reset between samples");

    chk_avg_no_reset: assert property (
        @(posedge clk) disable iff (!rst_n)
        mode_reg == dsadc_pkg::MODE_FAST_AVG && !start_evt |=> !mod_rst)
        else $error("modulator reset during fast average");

    chk_cont_keeps_on: assert property (
        @(posedge clk) disable iff (!rst_n)
        capture && mode_reg == dsadc_pkg::MODE_CONT && !stop_evt |=> state_reg == dsadc_pkg::ST_RUN && !mod_rst)
        else $error("continuous mode stopped or reset");
endmodule

/* tb/dsadc_mod_model.sv */
// Modulator bitstream source and periodic start pacer for the converter bench
`timescale 1ns/1ps
module dsadc_mod_model #(
    parameter int PERIOD = 200
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic mod_en,
    input wire logic level,
    input wire logic pace_en,
    output logic mod_bit,
    output logic soc
);
    int cnt;

    // ****************************************
    // Bitstream
    // ****************************************
    // New bit only on a modulator sample, like the real loop
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            mod_bit <= 1'b0;
        end else if (mod_en) begin
            mod_bit <= level;
        end
    end

    // ****************************************
    // Start pacing
    // ****************************************
    // periodic start pulse
    // Pulse held four clocks so the pin synchroniser sees it
    always_ff @(posedge clk) begin
        if (!rst_n || !pace_en) begin
            cnt <= 0;
            soc <= 1'b0;
        end else begin
            cnt <= (cnt == PERIOD - 1) ? 0 : cnt + 1;
            soc <= (cnt < 4);
        end
    end
endmodule

/* tb/delta_sigma_adc_conversion_control_tb.sv */
// Self-checking bench of the delta-sigma conversion control
`timescale 1ns/1ps
module delta_sigma_adc_conversion_control_tb;
    localparam int R = 4;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic [4:0] addr = 5'h00;
    logic [31:0] wdata = 32'h0;
    logic wr = 1'b0;
    logic rd = 1'b0;
    logic level = 1'b0;
    logic pace_en = 1'b0;
    logic [31:0] rdata;
    logic mod_bit, soc, mod_en, mod_rst, buf_en, eoc, eoc_rd;
    logic [3:0] in_sel;
    logic [31:0] got;
    logic [4:0] zero_a [4] = '{5'h00, 5'h08, 5'h0c, 5'h14};
    int miscompares = 0;
    int tests_run = 0;
    int seed = 32'hf477;
    int pulses = 0;
    int elapsed, nexp, ch;
    int exp_q[$];

    dsadc_ctrl i_dsadc_ctrl (.clk(clk), .rst_n(rst_n), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
        .rdata(rdata), .mod_bit(mod_bit), .soc(soc), .mod_en(mod_en), .mod_rst(mod_rst), .buf_en(buf_en),
        .in_sel(in_sel), .eoc(eoc));
    dsadc_mod_model i_dsadc_mod_model (.clk(clk), .rst_n(rst_n), .mod_en(mod_en), .level(level),
        .pace_en(pace_en), .mod_bit(mod_bit), .soc(soc));

    initial begin
        forever #12.5 clk = ~clk;
    end

    always @(posedge clk) begin
        if (mod_rst === 1'b1) begin
            pulses++;
        end
    end

    // ****************************************
    // Bus and check tasks
    // ****************************************
    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] seen);
        tests_run++;
        if (exp !== seen) begin
            $display("BAD %s expected %h seen %h", what, exp, seen);
            miscompares++;
        end
    endtask

    task automatic wr_reg(input logic [4:0] a, input logic [31:0] d);
        @(posedge clk);
        wr <= 1'b1;
        addr <= a;
        wdata <= d;
        @(posedge clk);
        wr <= 1'b0;
        // Let the written registers settle before any look at them
        #1;
    endtask

    // Read data stand only in the cycle after the strobe
    task automatic rd_reg(input logic [4:0] a, output logic [31:0] d);
        @(posedge clk);
        rd <= 1'b1;
        addr <= a;
        #1 eoc_rd = eoc;
        @(posedge clk);
        rd <= 1'b0;
        @(negedge clk);
        d = rdata;
    endtask

    task automatic wait_eoc;
        elapsed = 0;
        while (eoc !== 1'b1 && elapsed < 800) begin
            @(posedge clk);
            #1;
            elapsed++;
        end
        if (eoc !== 1'b1) begin
            $display("BAD eoc expected 1 seen %b", eoc);
            miscompares++;
            end_of_test();
        end
    endtask

    task automatic end_of_test;
        $display("Checks %0d mismatches %0d", tests_run, miscompares);
        if (miscompares == 0 && tests_run > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask

    // ****************************************
    // Main sequence
    // ****************************************
    initial begin
        repeat (6) @(posedge clk);
        rst_n <= 1'b1;
        @(posedge clk);
        // Ratio 40e6/(3*192000)=69, shift 7 at reset
        rd_reg(dsadc_pkg::CFG_OFS, got);
        chk("cfg reset", 32'h0000_0745, got);
        for (int i = 0; i < 4; i++) begin
            rd_reg(zero_a[i], got);
            chk("reset or unmapped", 32'h0, got);
        end
        chk("outputs idle", 32'h0, 32'({eoc, buf_en, in_sel}));
        got = 32'h0;
        repeat (30) begin
            @(posedge clk);
            #1;
            got = got + 32'(mod_en);
        end
        chk("mod_en rate", 32'(30 / dsadc_pkg::MOD_DIV), got);
        ch = $random(seed) & 15;
        wr_reg(dsadc_pkg::CHAN_OFS, 32'(ch));
        chk("in_sel", 32'(ch), 32'(in_sel));
        rd_reg(dsadc_pkg::STAT_OFS, got);
        chk("settled after switch", 32'h0, got & 32'h4);
        wr_reg(dsadc_pkg::CTRL_OFS, 32'h4);
        chk("buf_en on", 32'h1, 32'(buf_en));
        wr_reg(dsadc_pkg::CTRL_OFS, 32'h0);
        chk("buf_en off", 32'h0, 32'(buf_en));
        for (int m = 0; m < 4; m++) begin
            level <= 1'($random(seed));
            repeat (10) @(posedge clk);
            wr_reg(dsadc_pkg::CFG_OFS, (m == 3 ? 32'h0001_0000 : 32'h0) | 32'(R));
            pulses = 0;
            wr_reg(dsadc_pkg::CTRL_OFS, 32'h8 | 32'(m));
            nexp = level ? R * R * R * (m == 3 ? 2 : 1) : 0;
            exp_q.push_back(nexp);
            wait_eoc();
            chk("settle time", 32'h1, 32'(elapsed >= 3 * R * dsadc_pkg::MOD_DIV));
            rd_reg(dsadc_pkg::STAT_OFS, got);
            chk("done flag", 32'h1, got & 32'h1);
            chk("eoc held", 32'h1, 32'(eoc));
            rd_reg(dsadc_pkg::RESULT_OFS, got);
            chk("eoc in read", 32'h0, 32'(eoc_rd));
            chk("result", 32'(exp_q.pop_front()), got);
            if (m == 0) begin
                repeat (60) @(posedge clk);
                chk("one conversion", 32'h0, 32'(eoc));
                rd_reg(dsadc_pkg::STAT_OFS, got);
                chk("standby", 32'h0, got & 32'h2);
            end else begin
                exp_q.push_back(nexp);
                wait_eoc();
                rd_reg(dsadc_pkg::RESULT_OFS, got);
                chk("next result", 32'(exp_q.pop_front()), got);
                chk("reset pulses", 32'h1, 32'(m == 1 ? pulses >= 2 : pulses == 1));
                wr_reg(dsadc_pkg::CTRL_OFS, 32'h10 | 32'(m));
                rd_reg(dsadc_pkg::STAT_OFS, got);
                chk("stopped", 32'h0, got & 32'h2);
            end
        end
        // Paced single conversions from the start pin
        level <= 1'b1;
        wr_reg(dsadc_pkg::CFG_OFS, 32'(R));
        // Single sample mode, no start bit: only the pin starts conversions
        wr_reg(dsadc_pkg::CTRL_OFS, 32'h0);
        pace_en <= 1'b1;
        for (int k = 0; k < 2; k++) begin
            wait_eoc();
            rd_reg(dsadc_pkg::RESULT_OFS, got);
            chk("paced result", 32'(R * R * R), got);
        end
        pace_en <= 1'b0;
        end_of_test();
    end
endmodule
